// ### shared/dsts_pkg.sv
package dsts_pkg;
  // sector and store geometry
  localparam int WORD_W     = 16;
  localparam int SECT_WORDS = 128;
  localparam int FIFO_DEPTH = 256;
  localparam int EXT_W      = 6;
  localparam int CNT_W      = 9;
  // watchdog: time in ms and derived cycle count at the controller clock
  localparam int CLK_HZ      = 50_000_000;
  localparam int WDOG_MS     = 550;
  localparam int WDOG_CYCLES = WDOG_MS * (CLK_HZ / 1000);
  // serial framing counters
  localparam logic [3:0] BIT_LAST   = 4'hf;
  localparam logic [1:0] HDR_LAST   = 2'h2;
  localparam logic [1:0] HDR_CMP    = 2'h0;
  localparam logic [7:0] SECT_LAST  = 8'h7f;
  localparam logic [CNT_W-1:0] HALF = 9'h080;
  localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000;
  localparam logic [WORD_W-1:0] WORD_ONE  = 16'h0001;
  localparam logic [WORD_W-1:0] WC_LAST   = 16'hffff;
  // crc generator
  localparam logic [WORD_W-1:0] CRC_POLY = 16'h8005;
  localparam logic [WORD_W-1:0] CRC_INIT = 16'h0000;

  typedef enum logic [1:0] {
    FN_WRITE,
    FN_WCHECK,
    FN_READ,
    FN_READ_NOHDR
  } dsts_func_e;

  // command set loaded by software before start
  typedef struct packed {
    dsts_func_e         func;
    logic               int_enable;
    logic [EXT_W-1:0]   memory_address_extension;
    logic [WORD_W-1:0]  memory_address_low;
    logic [WORD_W-1:0]  transfer_word_counter;
    logic [WORD_W-1:0]  disk_sector_address;
  } dsts_cfg_s;

  // status bits seen by software
  typedef struct packed {
    logic controller_ready_bit;
    logic operation_incomplete;
    logic data_crc_error_flag;
    logic late_or_header_missing_flag;
  } dsts_stat_s;
endpackage : dsts_pkg

// ### rtl/dsts_fifo.sv
`timescale 1ns/1ps
// word store between dma and serializer; head word reads straight from the array
module dsts_fifo #(
  parameter int W     = dsts_pkg::WORD_W,
  parameter int DEPTH = dsts_pkg::FIFO_DEPTH,
  parameter int CW    = dsts_pkg::CNT_W
) (
  input  wire logic          clk_in,     // controller clock
  input  wire logic          resetn_in,  // async reset, active low
  input  wire logic          flush_in,   // drop all contents
  input  wire logic          push_in,    // write one word
  input  wire logic [W-1:0]  data_in,    // word to write
  input  wire logic          pop_in,     // remove head word
  output logic      [W-1:0]  data_out,   // head word
  output logic      [CW-1:0] count_out   // words held
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wp_q, rp_q;
  logic [CW-1:0] cnt_q;
  wire           do_push = push_in && (cnt_q != CW'(DEPTH));
  wire           do_pop  = pop_in && (cnt_q != '0);

  assign data_out  = mem[rp_q];
  assign count_out = cnt_q;

  // storage has no reset; only the pointers and the count need a defined value
  always_ff @(posedge clk_in) begin
    if (do_push) begin
      mem[wp_q] <= data_in;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else if (flush_in) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      wp_q  <= wp_q + AW'(do_push);
      rp_q  <= rp_q + AW'(do_pop);
      cnt_q <= cnt_q + CW'(do_push) - CW'(do_pop);
    end
  end
endmodule : dsts_fifo

// ### rtl/dsts_crc.sv
`timescale 1ns/1ps
// serial crc, msb first; a field followed by its own crc leaves zero
module dsts_crc (
  input  wire logic        clk_in,     // controller clock
  input  wire logic        resetn_in,  // async reset, active low
  input  wire logic        clear_in,   // restart at init value
  input  wire logic        step_in,    // absorb one bit
  input  wire logic        bit_in,     // serial bit
  output logic      [15:0] crc_out     // running remainder
);
  logic [15:0] crc_q;
  wire         fb = crc_q[15] ^ bit_in;
  wire  [15:0] crc_d = {crc_q[14:0], 1'b0} ^ (fb ? dsts_pkg::CRC_POLY : dsts_pkg::WORD_ZERO);

  assign crc_out = crc_q;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      crc_q <= dsts_pkg::CRC_INIT;
    end else if (clear_in) begin
      crc_q <= dsts_pkg::CRC_INIT;
    end else if (step_in) begin
      crc_q <= crc_d;
    end
  end
endmodule : dsts_crc

// ### rtl/dsts_seq.sv
`timescale 1ns/1ps
module dsts_seq #(
  parameter int WDOG_CYCLES = dsts_pkg::WDOG_CYCLES,
  parameter int FIFO_DEPTH  = dsts_pkg::FIFO_DEPTH
) (
  input  wire logic                     clk_in,                 // controller clock
  input  wire logic                     resetn_in,              // async reset, active low
  input  wire logic                     cmd_start_in,           // pulse: take cfg_in, start
  input  wire dsts_pkg::dsts_cfg_s      cfg_in,                 // command and parameters
  output dsts_pkg::dsts_stat_s          stat_out,               // status flags
  output logic                          int_request_out,        // pulse at completion
  output logic [dsts_pkg::WORD_W-1:0]   disk_sector_address_out, // current disk address
  input  wire logic                     drive_ready_in,         // drive ready level
  input  wire logic                     sector_pulse_in,        // pulse per sector
  input  wire logic                     bit_strobe_in,          // pulse per serial bit cell
  input  wire logic                     separated_read_data_in, // nrz bit from separator
  output logic                          write_gate_out,         // write enable to drive
  output logic                          write_data_out,         // serial write bit
  output logic [1:0]                    write_precomp_out,      // {early, late} shift
  output logic                          dma_req_out,            // wants a memory word
  input  wire logic                     dma_in_valid_in,        // memory word present
  input  wire logic [dsts_pkg::WORD_W-1:0] dma_in_data_in,      // word from memory
  output logic                          dma_out_valid_out,      // word for memory
  output logic [dsts_pkg::WORD_W-1:0]   dma_out_data_out,       // word to memory
  input  wire logic                     dma_out_ready_in,       // memory took word
  output logic [dsts_pkg::EXT_W+dsts_pkg::WORD_W-1:0] dma_addr_out // memory address
);
  localparam int AW = dsts_pkg::EXT_W + dsts_pkg::WORD_W;
  localparam int CW = dsts_pkg::CNT_W;

  typedef enum logic [3:0] {
    ST_IDLE, ST_WAIT_RDY, ST_WAIT_SECT, ST_HDR, ST_HDR_END,
    ST_DATA_LD, ST_DATA, ST_DATA_CRC_ERROR_FLAG_LD, ST_DATA_CRC_ERROR_FLAG, ST_SECT_END, ST_FINISH
  } dsts_state_e;

  dsts_state_e          st_q;
  dsts_pkg::dsts_func_e func_q;
  logic                 ie_q, rdy_q, opi_q, data_crc_error_flag_q, late_q, int_q;
  logic [AW-1:0]        addr_q;
  logic [15:0]          wc_q, dar_q, sh_q;
  logic                 wc_done_q, dma_en_q, miss_q, wg_q, wd_q;
  logic [1:0]           pc_q, hw_q;
  logic [3:0]           bit_q;
  logic [7:0]           word_q;
  logic [31:0]          wdog_q;

  // fifo and crc hookups
  logic [15:0]   fifo_head, crc_val;
  logic [CW-1:0] fifo_cnt;

  // direction and decoded conditions
  wire wr_dir   = (func_q == dsts_pkg::FN_WRITE) || (func_q == dsts_pkg::FN_WCHECK);
  wire is_write = (func_q == dsts_pkg::FN_WRITE);
  wire fifo_empty = (fifo_cnt == '0);
  wire fifo_full  = (fifo_cnt == CW'(FIFO_DEPTH));
  wire half_full  = (fifo_cnt >= dsts_pkg::HALF);
  wire half_room  = ((CW'(FIFO_DEPTH) - fifo_cnt) >= dsts_pkg::HALF);
  wire wdog_hit   = !rdy_q && (wdog_q >= WDOG_CYCLES - 1);
  wire strobe     = bit_strobe_in;
  wire rd         = separated_read_data_in;
  wire last_bit   = (bit_q == dsts_pkg::BIT_LAST);
  wire last_word  = (word_q == dsts_pkg::SECT_LAST);
  wire ser_bit    = sh_q[15]; // fifo_serial_output during write check

  // dma handshakes; memory words count up the two's complement counter
  wire dma_in_fire  = dma_req_out && dma_in_valid_in;
  wire dma_out_fire = dma_out_valid_out && dma_out_ready_in;
  wire dma_fire     = dma_in_fire || dma_out_fire;
  assign dma_req_out       = dma_en_q && wr_dir && !wc_done_q && !fifo_full;
  assign dma_out_valid_out = dma_en_q && !wr_dir && !wc_done_q && !fifo_empty;
  assign dma_out_data_out  = fifo_head;
  assign dma_addr_out      = addr_q;

  // serial datapath strobes
  wire in_data  = (st_q == ST_DATA) && strobe;
  wire in_data_crc_error_flag  = (st_q == ST_DATA_CRC_ERROR_FLAG) && strobe;
  wire in_hdr   = (st_q == ST_HDR) && strobe;
  wire word_end = in_data && last_bit;
  // serializer pops at word load; dma drains on the read side
  wire ser_load = (st_q == ST_DATA_LD) || (word_end && !last_word);
  wire ser_pop  = wr_dir && ser_load && !fifo_empty;
  wire rd_push  = !wr_dir && word_end;
  wire fifo_pop = wr_dir ? ser_pop : dma_out_fire;
  wire flush    = (st_q == ST_FINISH) || cmd_start_in;
  // zero words once supplied data is gone
  wire [15:0] next_word = fifo_empty ? dsts_pkg::WORD_ZERO : fifo_head;
  // store runs dry before the count ends: data late
  wire underrun = wr_dir && ser_load && fifo_empty && !wc_done_q;

  // crc input is the write stream on write, disk stream otherwise
  wire crc_clear = (st_q == ST_WAIT_SECT) || (st_q == ST_HDR_END);
  wire crc_bit   = is_write ? ser_bit : rd;
  wire crc_step  = in_hdr || in_data || (in_data_crc_error_flag && !is_write);

  dsts_fifo #(
    .W     (dsts_pkg::WORD_W),
    .DEPTH (FIFO_DEPTH),
    .CW    (CW)
  ) u_fifo (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .flush_in  (flush),
    .push_in   (dma_in_fire || rd_push),
    .data_in   (wr_dir ? dma_in_data_in : {sh_q[14:0], rd}),
    .pop_in    (fifo_pop),
    .data_out  (fifo_head),
    .count_out (fifo_cnt)
  );

  dsts_crc u_crc (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .clear_in  (crc_clear),
    .step_in   (crc_step),
    .bit_in    (crc_bit),
    .crc_out   (crc_val)
  );

  assign stat_out = '{controller_ready_bit: rdy_q, operation_incomplete: opi_q,
                      data_crc_error_flag: data_crc_error_flag_q, late_or_header_missing_flag: late_q};
  assign int_request_out         = int_q;
  assign disk_sector_address_out = dar_q;
  assign write_gate_out          = wg_q;
  assign write_data_out          = wd_q;
  assign write_precomp_out       = pc_q;

  // host-side counters: address walks and word count overflows to zero
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      addr_q    <= '0;
      wc_q      <= dsts_pkg::WORD_ZERO;
      wc_done_q <= 1'b0;
    end else if (cmd_start_in) begin
      addr_q    <= {cfg_in.memory_address_extension, cfg_in.memory_address_low};
      wc_q      <= cfg_in.transfer_word_counter;
      wc_done_q <= 1'b0;
    end else if (dma_fire) begin
      addr_q    <= addr_q + AW'(1);
      wc_q      <= wc_q + dsts_pkg::WORD_ONE;
      wc_done_q <= (wc_q == dsts_pkg::WC_LAST);
    end
  end

  // watchdog runs whenever a command is in progress
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wdog_q <= '0;
    end else if (rdy_q || cmd_start_in) begin
      wdog_q <= '0;
    end else begin
      wdog_q <= wdog_q + 32'h1;
    end
  end

  // precompensation: shift a one early before a zero, late after one
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wd_q   <= 1'b0;
      pc_q   <= 2'b00;
    end else if (is_write && wg_q && (in_data || in_data_crc_error_flag)) begin
      wd_q   <= ser_bit;
      // wd_q still holds the bit sent just before this one
      pc_q   <= {ser_bit & ~sh_q[14], ser_bit & wd_q};
    end
  end

  // shift register: serializes on write, deserializes on read
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sh_q <= dsts_pkg::WORD_ZERO;
    end else if (ser_load && wr_dir) begin
      sh_q <= next_word;
    end else if (st_q == ST_DATA_CRC_ERROR_FLAG_LD) begin
      sh_q <= is_write ? crc_val : dsts_pkg::WORD_ZERO;
    end else if (in_data || in_data_crc_error_flag) begin
      sh_q <= {sh_q[14:0], rd};
    end
  end

  // bit and word counters within header and sector
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      bit_q  <= '0;
      word_q <= '0;
      hw_q   <= '0;
    end else if ((st_q == ST_WAIT_SECT) || (st_q == ST_DATA_LD) || (st_q == ST_DATA_CRC_ERROR_FLAG_LD)) begin
      bit_q  <= '0;
      word_q <= '0;
      hw_q   <= '0;
    end else if (in_hdr || in_data || in_data_crc_error_flag) begin
      bit_q  <= bit_q + 4'h1;
      hw_q   <= hw_q + 2'(in_hdr && last_bit);
      word_q <= word_q + 8'(in_data && last_bit);
    end
  end

  // sequencer
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_q     <= ST_IDLE;
      func_q   <= dsts_pkg::FN_WRITE;
      ie_q     <= 1'b0;
      rdy_q    <= 1'b1;
      opi_q    <= 1'b0;
      data_crc_error_flag_q   <= 1'b0;
      late_q   <= 1'b0;
      int_q    <= 1'b0;
      dar_q    <= dsts_pkg::WORD_ZERO;
      dma_en_q <= 1'b0;
      miss_q   <= 1'b0;
      wg_q     <= 1'b0;
    end else begin
      int_q <= 1'b0;
      if (cmd_start_in) begin
        func_q   <= cfg_in.func;
        ie_q     <= cfg_in.int_enable;
        dar_q    <= cfg_in.disk_sector_address;
        rdy_q    <= 1'b0;
        opi_q    <= 1'b0;
        data_crc_error_flag_q   <= 1'b0;
        late_q   <= 1'b0;
        wg_q     <= 1'b0;
        // write side fills the store at once; read waits for the drive
        dma_en_q <= (cfg_in.func == dsts_pkg::FN_WRITE) || (cfg_in.func == dsts_pkg::FN_WCHECK);
        st_q     <= ST_WAIT_RDY;
      end else if (wdog_hit && (st_q != ST_FINISH)) begin
        opi_q <= 1'b1;
        // while still hunting a header, timeout means header missing
        if ((st_q == ST_WAIT_SECT) || (st_q == ST_HDR) || (st_q == ST_HDR_END)) begin
          late_q <= 1'b1;
        end
        st_q <= ST_FINISH;
      end else begin
        case (st_q)
          ST_IDLE: begin
            st_q <= ST_IDLE;
          end
          ST_WAIT_RDY: begin
            if (drive_ready_in) begin
              dma_en_q <= 1'b1;
              st_q     <= ST_WAIT_SECT;
            end
          end
          ST_WAIT_SECT: begin
            miss_q <= 1'b0;
            if (sector_pulse_in && drive_ready_in) begin
              if (func_q != dsts_pkg::FN_READ_NOHDR) begin
                st_q <= ST_HDR;
              end else if (half_room) begin
                // the header field still passes under the head, unchecked
                st_q <= ST_HDR;
              end else begin
                late_q <= 1'b1;
                st_q   <= ST_FINISH;
              end
            end
          end
          ST_HDR: begin
            // first header word against the disk address, msb first
            if (in_hdr && (hw_q == dsts_pkg::HDR_CMP) && (rd != dar_q[~bit_q])) begin
              miss_q <= 1'b1;
            end
            if (in_hdr && last_bit && (hw_q == dsts_pkg::HDR_LAST)) begin
              st_q <= ST_HDR_END;
            end
          end
          ST_HDR_END: begin
            if (func_q == dsts_pkg::FN_READ_NOHDR) begin
              st_q <= ST_DATA_LD;
            end else if (miss_q) begin
              st_q <= ST_WAIT_SECT;
            end else if (crc_val != dsts_pkg::CRC_INIT) begin
              // matching header only; opi marks it as a header error
              data_crc_error_flag_q <= 1'b1;
              opi_q  <= 1'b1;
              st_q   <= ST_FINISH;
            end else if (wr_dir ? (half_full || wc_done_q) : half_room) begin
              st_q <= ST_DATA_LD;
            end else begin
              st_q <= ST_WAIT_SECT;
            end
          end
          ST_DATA_LD: begin
            wg_q <= is_write;
            st_q <= ST_DATA;
          end
          ST_DATA: begin
            if (underrun) begin
              late_q <= 1'b1;
            end
            if (in_data && (func_q == dsts_pkg::FN_WCHECK) && (rd != ser_bit)) begin
              data_crc_error_flag_q <= 1'b1;
            end
            if (word_end && last_word) begin
              st_q <= ST_DATA_CRC_ERROR_FLAG_LD;
            end
          end
          ST_DATA_CRC_ERROR_FLAG_LD: begin
            st_q <= ST_DATA_CRC_ERROR_FLAG;
          end
          ST_DATA_CRC_ERROR_FLAG: begin
            if (in_data_crc_error_flag && last_bit) begin
              st_q <= ST_SECT_END;
            end
          end
          ST_SECT_END: begin
            wg_q  <= 1'b0;
            dar_q <= dar_q + dsts_pkg::WORD_ONE;
            if (!is_write && (crc_val != dsts_pkg::CRC_INIT)) begin
              data_crc_error_flag_q <= 1'b1;
              st_q   <= ST_FINISH;
            end else if (data_crc_error_flag_q || late_q) begin
              st_q <= ST_FINISH;
            end else if (wc_done_q && (!wr_dir || fifo_empty)) begin
              st_q <= ST_FINISH;
            end else begin
              st_q <= ST_WAIT_SECT;
            end
          end
          ST_FINISH: begin
            rdy_q    <= 1'b1;
            int_q    <= ie_q;
            dma_en_q <= 1'b0;
            wg_q     <= 1'b0;
            st_q     <= ST_IDLE;
          end
          default: begin
            st_q <= ST_IDLE;
          end
        endcase
      end
    end
  end
endmodule : dsts_seq

// ### bench/dsts_seq_assertions.sv
`timescale 1ns/1ps
// port-level checks of the sequencer
module dsts_seq_checker (
  input wire logic                 clk_in,                  // controller clock
  input wire logic                 resetn_in,               // async reset, active low
  input wire logic                 cmd_start_in,            // command start
  input wire dsts_pkg::dsts_stat_s stat_out,                // status flags
  input wire logic                 int_request_out,         // completion pulse
  input wire logic [15:0]          disk_sector_address_out, // disk address
  input wire logic                 bit_strobe_in,           // bit cell strobe
  input wire logic                 write_gate_out,          // write gate
  input wire logic                 dma_req_out,             // dma fill request
  input wire logic                 dma_in_valid_in,         // memory word present
  input wire logic                 dma_out_valid_out,       // word for memory
  input wire logic                 dma_out_ready_in,        // memory took word
  input wire logic [21:0]          dma_addr_out             // memory address
);
  logic [11:0] gcnt_q;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  // strobes taken under the gate; a sector is 2048 data bits plus 16 crc bits
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in || !write_gate_out) gcnt_q <= 12'h000;
    else if (bit_strobe_in) gcnt_q <= gcnt_q + 12'h001;
  end
  sequence s_start; cmd_start_in && stat_out.controller_ready_bit; endsequence
  sequence s_cleared; !stat_out.controller_ready_bit && (stat_out[2:0] == 3'h0); endsequence
  property p_start; s_start |=> s_cleared; endproperty
  property p_req; dma_req_out |-> !stat_out.controller_ready_bit; endproperty
  property p_gate; write_gate_out |-> !stat_out.controller_ready_bit; endproperty
  property p_irq; int_request_out |-> $rose(stat_out.controller_ready_bit); endproperty
  property p_hold; stat_out.controller_ready_bit && !cmd_start_in |=> $stable(stat_out); endproperty
  property p_fill; dma_req_out && dma_in_valid_in |=> dma_addr_out == $past(dma_addr_out) + 22'h1; endproperty
  property p_drain; dma_out_valid_out && dma_out_ready_in |=> dma_addr_out == $past(dma_addr_out) + 22'h1; endproperty
  property p_dsa;
    !$past(cmd_start_in) && disk_sector_address_out != $past(disk_sector_address_out)
      |-> disk_sector_address_out == $past(disk_sector_address_out) + 16'h1;
  endproperty
  property p_len; $fell(write_gate_out) |-> gcnt_q inside {[12'd2064:12'd2065]}; endproperty
  property p_opi; $rose(stat_out.operation_incomplete) |-> ##[0:4] stat_out.controller_ready_bit; endproperty
  a_start: assert property (p_start) else $error("start left status set");
  a_req: assert property (p_req) else $error("dma request while ready");
  a_gate: assert property (p_gate) else $error("write gate while ready");
  a_irq: assert property (p_irq) else $error("interrupt without ready rise");
  a_hold: assert property (p_hold) else $error("status moved while idle");
  a_fill: assert property (p_fill) else $error("fill address not stepped");
  a_drain: assert property (p_drain) else $error("drain address not stepped");
  a_dsa: assert property (p_dsa) else $error("disk address jumped");
  a_len: assert property (p_len) else $error("write gate length wrong");
  a_opi: assert property (p_opi) else $error("incomplete without halt");
endmodule : dsts_seq_checker

// ### bench/dsts_drive_model.sv
`timescale 1ns/1ps
// spinning drive: pulse, header, data field, forever; records written bits
module dsts_drive_model (
  input  wire logic        clk_in,           // controller clock
  input  wire logic        clr_in,           // clear write capture
  input  wire logic [15:0] hdr_in,           // header address word
  input  wire logic [1:0]  bad_in,           // corrupt {header, data} crc
  input  wire logic        gate_in,          // write gate
  input  wire logic        wdata_in,         // serial write bit
  output logic             sector_pulse_out, // sector mark
  output logic             bit_strobe_out,   // bit cell strobe
  output logic             rd_data_out,      // separated read bit
  output logic [47:0]      cap_out,          // first written bits
  output logic [11:0]      ncap_out          // written bit count
);
  logic [15:0] crc;
  logic        tk_q;
  function automatic logic [15:0] step(input logic [15:0] c, input logic b);
    return {c[14:0], 1'b0} ^ ((c[15] ^ b) ? 16'h8005 : 16'h0000);
  endfunction : step
  // gaps carry the inverse bit so a late sample never looks right by luck
  task automatic send(input logic b);
    @(posedge clk_in);
    rd_data_out <= b;
    bit_strobe_out <= 1'b1;
    crc = step(crc, b);
    @(posedge clk_in);
    bit_strobe_out <= 1'b0;
    rd_data_out <= ~b;
    @(posedge clk_in);
  endtask : send
  task automatic word(input logic [15:0] w);
    for (int i = 15; i >= 0; i--) send(w[i]);
  endtask : word
  task automatic tail(input logic flip);
    logic [15:0] c;
    c = crc ^ {15'h0000, flip};
    word(c);
  endtask : tail
  initial begin
    sector_pulse_out = 1'b0;
    bit_strobe_out = 1'b0;
    rd_data_out = 1'b0;
    forever begin
      @(posedge clk_in);
      sector_pulse_out <= 1'b1;
      @(posedge clk_in);
      sector_pulse_out <= 1'b0;
      crc = 16'h0000;
      word(hdr_in);
      word(16'h0000);
      tail(bad_in[1]);
      crc = 16'h0000;
      for (int k = 0; k < 128; k++) word({8'ha5, k[7:0]});
      tail(bad_in[0]);
    end
  end
  // take the write bit one cycle after each strobe seen under the gate
  always @(posedge clk_in) begin
    tk_q <= bit_strobe_out && gate_in;
    if (clr_in) ncap_out <= 12'h000;
    else if (tk_q) begin
      ncap_out <= ncap_out + 12'h001;
      if (ncap_out < 12'd48) cap_out <= {cap_out[46:0], wdata_in};
    end
  end
endmodule : dsts_drive_model

// ### bench/dsts_seq_bench.sv
`timescale 1ns/1ps
// rows of read commands, then write and header-missing cases
module dsts_seq_bench;
  typedef struct packed {
    dsts_pkg::dsts_func_e f;
    logic [15:0] wc, hdr;
    logic [1:0]  bad;
    logic [3:0]  st;
    logic [15:0] dsa;
    logic [1:0]  o;
  } dsts_row_s;
  logic clk_in = 1'b0, resetn_in = 1'b0, cmd_start_in = 1'b0, drive_ready_in = 1'b0;
  logic dma_in_valid_in = 1'b0, dma_out_ready_in = 1'b1, int_request_out, write_gate_out, write_data_out;
  logic dma_req_out, dma_out_valid_out, sector_pulse_in, bit_strobe_in, separated_read_data_in;
  logic [15:0] dma_in_data_in = 16'hc35a, hdr = 16'h0000, disk_sector_address_out, dma_out_data_out, first_q;
  logic [1:0] bad = 2'h0, write_precomp_out;
  logic [1:0] pc_seen = 2'h0;
  logic [21:0] dma_addr_out;
  logic [47:0] cap;
  logic [11:0] ncap;
  dsts_pkg::dsts_cfg_s cfg_in = '0;
  dsts_pkg::dsts_stat_s stat_out;
  int n_mismatch = 0, cmp_count = 0, n_int = 0, n_out = 0;
  dsts_row_s rows [4] = '{
    '{dsts_pkg::FN_READ, 16'hfffe, 16'h0042, 2'h0, 4'h8, 16'h0043, 2'h2},
    '{dsts_pkg::FN_READ, 16'hfffe, 16'h0042, 2'h1, 4'ha, 16'h0043, 2'h2},
    '{dsts_pkg::FN_READ, 16'hfffe, 16'h0042, 2'h2, 4'he, 16'h0042, 2'h0},
    '{dsts_pkg::FN_READ_NOHDR, 16'hfffe, 16'h0777, 2'h0, 4'h8, 16'h0000, 2'h2}};
  // watchdog cut short to keep the run brief; a command that finds its header spans at most two sectors
  dsts_seq #(.WDOG_CYCLES(16000), .FIFO_DEPTH(256)) dsts_seq_inst (.clk_in, .resetn_in, .cmd_start_in,
    .cfg_in, .stat_out, .int_request_out, .disk_sector_address_out, .drive_ready_in, .sector_pulse_in,
    .bit_strobe_in, .separated_read_data_in, .write_gate_out, .write_data_out, .write_precomp_out,
    .dma_req_out, .dma_in_valid_in, .dma_in_data_in, .dma_out_valid_out, .dma_out_data_out,
    .dma_out_ready_in, .dma_addr_out);
  dsts_drive_model dsts_drive_model_inst (.clk_in, .clr_in(cmd_start_in), .hdr_in(hdr), .bad_in(bad),
    .gate_in(write_gate_out), .wdata_in(write_data_out), .sector_pulse_out(sector_pulse_in),
    .bit_strobe_out(bit_strobe_in), .rd_data_out(separated_read_data_in), .cap_out(cap), .ncap_out(ncap));
  always #10 clk_in = ~clk_in;
  // count completion pulses and words handed to memory
  always @(posedge clk_in) begin
    if (int_request_out) n_int++;
    if (write_gate_out) pc_seen <= pc_seen | write_precomp_out;
    if (dma_out_valid_out && dma_out_ready_in) begin
      if (n_out == 0) first_q <= dma_out_data_out;
      n_out++;
    end
  end
  task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] s);
    cmp_count++;
    if (s !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, s);
      n_mismatch++;
    end
  endtask : chk
  task automatic run(input dsts_row_s r);
    int i;
    i = 0;
    n_int = 0;
    n_out = 0;
    cfg_in <= '{r.f, 1'b1, 6'h01, 16'h2000, r.wc, 16'h0042};
    hdr <= r.hdr;
    bad <= r.bad;
    cmd_start_in <= 1'b1;
    @(posedge clk_in);
    cmd_start_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    while (!stat_out.controller_ready_bit && i < 20000) begin
      @(posedge clk_in);
      i++;
    end
    repeat (2) @(posedge clk_in);
    chk("status", r.st, stat_out);
    chk("irq", 1, n_int);
    chk("words", r.o, n_out);
    if (r.o != 2'h0) chk("first", 16'ha500, first_q);
    if (r.f != dsts_pkg::FN_READ_NOHDR) chk("dsa", r.dsa, disk_sector_address_out);
  endtask : run
  task automatic give_verdict();
    if (n_mismatch == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (100000) @(posedge clk_in);
    n_mismatch++;
    give_verdict();
  end
  initial begin
    repeat (5) @(posedge clk_in);
    resetn_in <= 1'b1;
    drive_ready_in <= 1'b1;
    @(posedge clk_in);
    chk("reset", 4'h8, stat_out);
    foreach (rows[i]) run(rows[i]);
    chk("addr", 22'h012002, dma_addr_out);
    dma_in_valid_in <= 1'b1;
    run('{dsts_pkg::FN_WRITE, 16'hfffe, 16'h0042, 2'h0, 4'h8, 16'h0043, 2'h0});
    chk("written", {16'hc35a, 16'hc35a, 16'h0000}, cap);
    chk("bits", 2064, ncap);
    chk("precomp", 2'h3, pc_seen);
    run('{dsts_pkg::FN_WCHECK, 16'hfffe, 16'h0042, 2'h0, 4'ha, 16'h0043, 2'h0});
    dma_in_valid_in <= 1'b0;
    run('{dsts_pkg::FN_READ, 16'hfffe, 16'h0099, 2'h0, 4'hd, 16'h0042, 2'h0});
    give_verdict();
  end
endmodule : dsts_seq_bench
bind dsts_seq dsts_seq_checker dsts_seq_checker_inst (.clk_in, .resetn_in, .cmd_start_in, .stat_out,
  .int_request_out, .disk_sector_address_out, .bit_strobe_in, .write_gate_out, .dma_req_out,
  .dma_in_valid_in, .dma_out_valid_out, .dma_out_ready_in, .dma_addr_out);
